// ==== logic/bcd_adjust_unit.sv ====
/*
 Combinational decimal correction of a packed BCD sum.
 Assumes the carry and digit carry come from the addition that made the sum.
*/
`include "datapath_map.svh"

module bcd_adjust_unit (
    // Sum from the accumulator and its flags
    input wire logic [7:0] sum,
    input wire logic carry,
    input wire logic digit_carry,
    // Corrected byte and new carry
    output logic [7:0] adjusted,
    output logic adjusted_carry
);
    logic [8:0] low_fixed;
    logic [8:0] high_fixed;

    always_comb begin
        low_fixed = {1'b0, sum};
        if (sum[3:0] > `BCD_NIBBLE_MAX || digit_carry) begin
            low_fixed = low_fixed + {5'h00, `BCD_SIX};
        end
        high_fixed = low_fixed;
        // Carry out of the low fix counts as a high digit above nine
        if (low_fixed[7:4] > `BCD_NIBBLE_MAX || carry || low_fixed[8]) begin
            high_fixed = low_fixed + {1'b0, `BCD_SIX, 4'h0};
        end
        adjusted = high_fixed[7:0];
        adjusted_carry = carry | high_fixed[8];
    end
endmodule

// ==== logic/byte_move_adjust_datapath.sv ====
/*
 Execution datapath for decimal adjust, move file, decrement file and
 the two word pointer load, with file address formation.
 Assumes a decoder on sys_clk that presents one operation per cycle and a
 data memory with combinational read; writes land one cycle later.
*/
`include "datapath_map.svh"

module byte_move_adjust_datapath
    import datapath_pkg::*;
#(
    parameter int DATA_WIDTH = 8,
    parameter int ADDR_WIDTH = 12,
    parameter int POINTER_COUNT = 3
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Operation from the decoder
    input wire logic op_valid,
    input wire op_code_type op_code,
    input wire logic [7:0] file_addr,
    input wire logic dest_sel,
    input wire logic access_sel,
    input wire logic [1:0] pointer_sel,
    input wire logic [3:0] literal_high,
    input wire logic [7:0] literal_low,
    output logic busy,
    // Core context
    input wire logic extended_set,
    input wire logic [3:0] bank_select_register,
    // Sum loaded by the core adder
    input wire logic sum_valid,
    input wire logic [7:0] sum_data,
    input wire logic sum_carry,
    input wire logic sum_digit_carry,
    // Data memory
    output logic [ADDR_WIDTH-1:0] mem_addr,
    input wire logic [DATA_WIDTH-1:0] mem_rdata,
    output logic mem_we,
    output logic [ADDR_WIDTH-1:0] mem_waddr,
    output logic [DATA_WIDTH-1:0] mem_wdata,
    // Architectural state
    output logic [DATA_WIDTH-1:0] acc,
    output logic carry,
    output logic digit_carry_flag,
    output logic negative,
    output logic overflow,
    output logic zero,
    output logic [POINTER_COUNT*ADDR_WIDTH-1:0] pointers
);
    dp_state_type state;
    logic [ADDR_WIDTH-1:0] pointer_reg [POINTER_COUNT];
    logic [1:0] load_target;
    logic [7:0] adjusted;
    logic adjusted_carry;
    logic [7:0] dec_result;
    logic run_op;
    logic result_valid;
    logic [7:0] result;

    function automatic logic [11:0] file_address(input logic [7:0] f, input logic a,
            input logic ext, input logic [3:0] bank, input logic [11:0] base);
        logic [11:0] addr;
        addr = {bank, f};
        if (!a) begin
            if (ext && f <= `INDEX_LIMIT) begin
                addr = base + {4'h0, f};
            end else if (f < `ACCESS_SPLIT) begin
                addr = {`ACCESS_LOW_BANK, f};
            end else begin
                addr = {`ACCESS_HIGH_BANK, f};
            end
        end
        return addr;
    endfunction

    bcd_adjust_unit adjust_unit (
        .sum(acc),
        .carry(carry),
        .digit_carry(digit_carry_flag),
        .adjusted(adjusted),
        .adjusted_carry(adjusted_carry)
    );

    assign busy = (state == ST_LOAD_LOW);
    // A second pointer word is never decoded as an operation
    assign run_op = op_valid && !busy;
    assign dec_result = mem_rdata - 8'h01;
    assign mem_addr = file_address(file_addr, access_sel, extended_set,
        bank_select_register, pointer_reg[`INDEX_POINTER]);

    for (genvar i = 0; i < POINTER_COUNT; i++) begin : g_ptr
        assign pointers[i*ADDR_WIDTH +: ADDR_WIDTH] = pointer_reg[i];
    end

    always_comb begin
        result_valid = 1'b0;
        result = mem_rdata;
        if (run_op) begin
            case (op_code)
                OP_MOVE_FILE: begin
                    result_valid = 1'b1;
                    result = mem_rdata;
                end
                OP_DECREMENT_FILE: begin
                    result_valid = 1'b1;
                    result = dec_result;
                end
                default: begin
                    result_valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= ST_RUN;
            load_target <= 2'h0;
        end else begin
            case (state)
                ST_RUN: begin
                    if (run_op && op_code == OP_LOAD_POINTER) begin
                        state <= ST_LOAD_LOW;
                        load_target <= pointer_sel;
                    end
                end
                ST_LOAD_LOW: begin
                    if (op_valid) begin
                        state <= ST_RUN;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < POINTER_COUNT; i++) begin
                pointer_reg[i] <= `POINTER_RESET;
            end
        end else if (run_op && op_code == OP_LOAD_POINTER) begin
            pointer_reg[pointer_sel][11:8] <= literal_high;
        end else if (busy && op_valid) begin
            pointer_reg[load_target][7:0] <= literal_low;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mem_we <= 1'b0;
            mem_waddr <= '0;
            mem_wdata <= '0;
        end else begin
            mem_we <= result_valid && dest_sel;
            mem_waddr <= mem_addr;
            mem_wdata <= result;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            acc <= `ACC_RESET;
        end else if (result_valid && !dest_sel) begin
            acc <= result;
        end else if (run_op && op_code == OP_DECIMAL_ADJUST) begin
            acc <= adjusted;
        end else if (sum_valid && !run_op) begin
            acc <= sum_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            carry <= 1'b0;
            digit_carry_flag <= 1'b0;
            negative <= 1'b0;
            overflow <= 1'b0;
            zero <= 1'b0;
        end else if (run_op && op_code == OP_DECREMENT_FILE) begin
            carry <= (mem_rdata != 8'h00);
            digit_carry_flag <= (mem_rdata[3:0] != 4'h0);
            negative <= dec_result[7];
            overflow <= (mem_rdata == `OVERFLOW_PATTERN);
            zero <= (dec_result == 8'h00);
        end else if (run_op && op_code == OP_MOVE_FILE) begin
            negative <= mem_rdata[7];
            zero <= (mem_rdata == 8'h00);
        end else if (run_op && op_code == OP_DECIMAL_ADJUST) begin
            carry <= adjusted_carry;
        end else if (sum_valid && !run_op) begin
            carry <= sum_carry;
            digit_carry_flag <= sum_digit_carry;
        end
    end

    sequence s_lp_first;
        op_valid && !busy && op_code == OP_LOAD_POINTER;
    endsequence

    sequence s_lp_second;
        busy && op_valid;
    endsequence

    a_adjust_low_digit: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (run_op && op_code == OP_DECIMAL_ADJUST && acc[3:0] > 4'h9)
        |=> acc[3:0] <= 4'h5 && carry >= $past(carry))
        else $error("decimal adjust left a low digit above nine");

    a_move_to_acc: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (run_op && op_code == OP_MOVE_FILE && !dest_sel)
        |=> acc == $past(mem_rdata) && !mem_we)
        else $error("move to accumulator lost the byte");

    a_move_to_file: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (run_op && op_code == OP_MOVE_FILE && dest_sel)
        |=> mem_we && mem_wdata == $past(mem_rdata) && mem_waddr == $past(mem_addr)
            && $stable(acc))
        else $error("move to file register wrote the wrong place");

    a_bank_direct: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        access_sel |-> mem_addr == {bank_select_register, file_addr})
        else $error("banked address not formed from bank and field");

    a_indexed_addr: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!access_sel && extended_set && file_addr <= 8'h5F)
        |-> mem_addr == pointer_reg[2] + {4'h0, file_addr})
        else $error("indexed offset not added to the pointer");

    a_pointer_load: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_lp_first ##1 s_lp_second
        |=> pointer_reg[$past(load_target)] ==
            {$past(literal_high, 2), $past(literal_low)})
        else $error("pointer load did not place both parts");

    a_pointer_busy: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_lp_first |=> busy)
        else $error("pointer load did not wait for its second word");

    a_decrement_flags: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (run_op && op_code == OP_DECREMENT_FILE && !dest_sel)
        |=> acc == $past(mem_rdata) - 8'h01 && zero == (acc == 8'h00)
            && carry == ($past(mem_rdata) != 8'h00) && negative == acc[7])
        else $error("decrement result or flags wrong");
endmodule

// ==== logic/datapath_map.svh ====
/*
 Offsets, limits and reset values of the byte move and adjust datapath.
 Included by the datapath modules; definitions only.
*/
`ifndef DATAPATH_MAP_SVH
`define DATAPATH_MAP_SVH

// Access bank: low part maps to bank 0, the rest to the top bank
`define ACCESS_SPLIT 8'h60
`define ACCESS_HIGH_BANK 4'hF
`define ACCESS_LOW_BANK 4'h0
// Highest file address taken as an indexed offset
`define INDEX_LIMIT 8'h5F
// Pointer used as the base of indexed offsets
`define INDEX_POINTER 2'h2
// Decimal adjust constants
`define BCD_NIBBLE_MAX 4'h9
`define BCD_SIX 4'h6
// Reset values and the decrement overflow pattern
`define ACC_RESET 8'h00
`define POINTER_RESET 12'h000
`define OVERFLOW_PATTERN 8'h80

`endif

// ==== logic/datapath_pkg.sv ====
/*
 Types shared by the byte move and adjust datapath.
 Assumes datapath_map.svh sits on the include path.
*/
package datapath_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_DECIMAL_ADJUST = 3'b001,
        OP_MOVE_FILE = 3'b010,
        OP_DECREMENT_FILE = 3'b011,
        OP_LOAD_POINTER = 3'b100
    } op_code_type;

    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_LOAD_LOW = 1'b1
    } dp_state_type;
endpackage

// ==== verif/byte_move_adjust_datapath_tb.sv ====
/*
 Self-checking bench for the byte move and adjust datapath.
 Assumes the data memory model and the design package are compiled first.
*/
module byte_move_adjust_datapath_tb import datapath_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, dest_sel = 1'b0, access_sel = 1'b0;
    logic extended_set = 1'b0, sum_valid = 1'b0, sum_carry = 1'b0, sum_digit_carry = 1'b0;
    op_code_type op_code = OP_NONE;
    logic [7:0] file_addr = 8'h00, literal_low = 8'h00, sum_data = 8'h00;
    logic [7:0] mem_rdata, mem_wdata, acc;
    logic [3:0] literal_high = 4'h0, bank_select_register = 4'h0;
    logic [1:0] pointer_sel = 2'h0;
    logic [11:0] mem_addr, mem_waddr;
    logic [35:0] pointers;
    logic busy, mem_we, carry, digit_carry_flag, negative, overflow, zero;
    int n_errors = 0, checks = 0, cycles = 0;
    logic [7:0] ref_mem [4096];
    logic [11:0] ref_ptr [3];

    byte_move_adjust_datapath dut_u (.sys_clk, .sys_rst, .op_valid, .op_code, .file_addr,
        .dest_sel, .access_sel, .pointer_sel, .literal_high, .literal_low, .busy, .extended_set,
        .bank_select_register, .sum_valid, .sum_data, .sum_carry, .sum_digit_carry, .mem_addr,
        .mem_rdata, .mem_we, .mem_waddr, .mem_wdata, .acc, .carry, .digit_carry_flag,
        .negative, .overflow, .zero, .pointers);
    data_memory_model mem_u (.sys_clk, .mem_addr, .mem_rdata, .mem_we, .mem_waddr, .mem_wdata);

    always #2 sys_clk = ~sys_clk;

    // Cuts a hang short; the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        logic [11:0] k, a;
        logic [7:0] s, r, e;
        int v;
        logic la;
        void'($urandom(32'heeb9));
        // Seed zeros and 80h so decrement borrow and overflow are reached
        for (int i = 0; i < 4096; i++) begin
            ref_mem[i] = i % 3 == 0 ? 8'h80 : i % 5 == 0 ? 8'h00 : 8'($urandom);
            mem_u.mem[i] = ref_mem[i];
        end
        repeat (2) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        chk("acc_reset", 0, acc);
        for (int p = 0; p < 3; p++) begin
            k = 12'($urandom);
            op_code = OP_LOAD_POINTER;
            pointer_sel = 2'(p);
            literal_high = k[11:8];
            op_valid = 1'b1;
            step();
            chk("busy", 1, busy);
            chk("ptr_high", k[11:8], pointers[12*p+8 +: 4]);
            op_code = OP_MOVE_FILE;
            literal_low = k[7:0];
            step();
            chk("busy", 0, busy);
            chk("pointer", k, pointers[12*p +: 12]);
            chk("mem_we", 0, mem_we);
            ref_ptr[p] = k;
        end
        // Valid stays up across the three loads, so they run back to back
        op_valid = 1'b0;
        for (int i = 0; i < 24; i++) begin
            s = i == 0 ? 8'hA5 : i == 1 ? 8'hCE : 8'($urandom);
            sum_carry = i > 1 ? 1'($urandom) : 1'b0;
            sum_digit_carry = i > 1 ? 1'($urandom) : 1'b0;
            sum_data = s;
            sum_valid = 1'b1;
            step();
            sum_valid = 1'b0;
            op_code = OP_DECIMAL_ADJUST;
            op_valid = 1'b1;
            step();
            op_valid = 1'b0;
            la = s % 16 > 9 || sum_digit_carry;
            v = s + (la ? 6 : 0);
            // A low digit carry reaches the high digit through the add itself
            v = v + ((v / 16 % 16 > 9 || sum_carry || v > 255) ? 96 : 0);
            chk("acc", 12'(v % 256), acc);
            chk("carry", sum_carry || v > 255, carry);
        end
        // Let an edge pass so valid is not raised in the step that lowered it
        step();
        // boundary 5Fh and 60h come first
        for (int i = 0; i < 160; i++) begin
            op_code = i % 2 ? OP_DECREMENT_FILE : OP_MOVE_FILE;
            file_addr = i < 2 ? 8'h5F + 8'(i / 1 % 2) : 8'($urandom);
            dest_sel = 1'($urandom);
            access_sel = i < 2 ? 1'b0 : 1'($urandom);
            extended_set = i < 2 ? 1'b1 : 1'($urandom);
            bank_select_register = 4'($urandom);
            op_valid = 1'b1;
            a = access_sel ? {bank_select_register, file_addr}
                : (extended_set && file_addr <= 8'h5F) ? ref_ptr[2] + 12'(file_addr)
                : {file_addr < 8'h60 ? 4'h0 : 4'hF, file_addr};
            #1;
            chk("mem_addr", a, mem_addr);
            r = ref_mem[a];
            e = op_code == OP_MOVE_FILE ? r : 8'(r - 8'h01);
            step();
            op_valid = 1'b0;
            if (dest_sel) begin
                chk("mem_we", 1, mem_we);
                chk("mem_waddr", a, mem_waddr);
                chk("mem_wdata", e, mem_wdata);
                ref_mem[a] = e;
            end else begin
                chk("acc", e, acc);
                chk("mem_we", 0, mem_we);
            end
            chk("zero", e == 8'h00, zero);
            chk("negative", e[7], negative);
            if (op_code == OP_DECREMENT_FILE) begin
                chk("carry", r != 8'h00, carry);
                chk("digit_carry", r[3:0] != 4'h0, digit_carry_flag);
                chk("overflow", r == 8'h80, overflow);
            end
            // Let the write land before the next read
            step();
        end
        end_sim();
    end
endmodule

// ==== verif/data_memory_model.sv ====
/*
 Data memory partner: combinational read, write taken on the clock edge.
 Assumes the datapath registers its write strobe, address and data.
*/
module data_memory_model (
    // Clock
    input wire logic sys_clk,
    // Read and write ports
    input wire logic [11:0] mem_addr,
    output logic [7:0] mem_rdata,
    input wire logic mem_we,
    input wire logic [11:0] mem_waddr,
    input wire logic [7:0] mem_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4096];
    assign mem_rdata = mem[mem_addr];
    // Plain always: the bench preloads this array by hierarchical write at time zero
    always @(posedge sys_clk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end
endmodule
